//--- rtl/fault_response_controller.sv
// Purpose: fault-response logic for output undercurrent and over temperature
// Assumes: temp_reading and ot_time_unit_ms come from logic on mclk
// Notes:   uc_fault_pin is asynchronous and is synchronised here
//          reads answer one edge after the strobe and hold until the next read
// How it works
// - response code 00 leaves the output running untouched after the fault.
// - code 01 keeps running for the delay, then applies the retry setting if the fault stays.
// - code 10 disables the output at once, then follows the retry setting.
// - code 11 keeps the output off while the fault lasts and re-enables it when it goes.
// - in every mode a fault pulls the alert line low and sets its sticky status bit.
// - the undercurrent response acts like the standard ones but sets its own status bit.
// - retry setting 000 means no restart; the output stays off until faults are cleared.
// - a nonzero undercurrent retry setting gives the number of restart attempts.
// - the undercurrent delay field counts 10 ms units directly.
// - the undercurrent wait between restarts is the delay field times 8.2 ms.
// - the over-temperature delay field n selects 2 to the n units, 1 up to 128.
// - the over-temperature unit comes from a separate unit register, not a constant.
// - a host-written 16-bit over-temperature fault threshold triggers that fault.
// - a separate host-written 16-bit warning threshold flags temperature early.
// - the over-temperature response byte has the same three-field layout.
`timescale 1ns/1ps
module fault_response_controller
  import fault_resp_pkg::*;
#(
  parameter int UC_DELAY_CYC = UC_DELAY_CYCLES,
  parameter int UC_RETRY_CYC = UC_RETRY_CYCLES,
  parameter int OT_BASE_CYC  = OT_BASE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_cmd,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        uc_fault_pin,
  input  wire logic [15:0] temp_reading,
  input  wire logic [7:0]  ot_time_unit_ms,
  input  wire logic        clear_faults,
  output logic             output_enable,
  output logic             alert_line_n_o,
  output logic             alert_line_n_oe,
  output logic             status_uc_fault,
  output logic             status_ot_fault,
  output logic             status_ot_warn
);

  typedef struct packed {
    logic [1:0]                 sync;
    logic [7:0]                 uc_resp;
    logic [7:0]                 ot_resp;
    logic [15:0]                ot_limit;
    logic [15:0]                ot_warn;
    logic [15:0]                rdata;
    fstate_t [NFAULT-1:0]       st;
    logic [NFAULT-1:0][23:0]    pre;
    logic [NFAULT-1:0][7:0]     units;
    logic [NFAULT-1:0][2:0]     tries;
    logic [NFAULT-1:0]          stat;
    logic                       warn;
    logic                       out_en;
  } ctl_t;

  ctl_t r;
  ctl_t next_r;

  // field pickers of a response byte
  function automatic resp_mode_t mode_of(input logic [7:0] b);
    return resp_mode_t'(b[MODE_HI:MODE_LO]);
  endfunction

  function automatic logic [2:0] retry_of(input logic [7:0] b);
    return b[RETRY_HI:RETRY_LO];
  endfunction

  function automatic logic [2:0] delay_of(input logic [7:0] b);
    return b[DELAY_HI:DELAY_LO];
  endfunction

  // one-hot select of the four commands; unknown codes select nothing
  function automatic logic [3:0] cmd_sel(input logic [7:0] c);
    logic [3:0] s;
    s = 4'h0;
    case (c)
      CMD_UC_RESP:  s = 4'h1;
      CMD_OT_LIMIT: s = 4'h2;
      CMD_OT_RESP:  s = 4'h4;
      CMD_OT_WARN:  s = 4'h8;
      default:      s = 4'h0;
    endcase
    return s;
  endfunction

  // response bytes sit in the low half, unknown codes read zero
  function automatic logic [15:0] read_word(input logic [3:0] s, input ctl_t c);
    logic [15:0] w;
    w = 16'h0000;
    if (s[0]) begin
      w = {8'h00, c.uc_resp};
    end
    if (s[1]) begin
      w = c.ot_limit;
    end
    if (s[2]) begin
      w = {8'h00, c.ot_resp};
    end
    if (s[3]) begin
      w = c.ot_warn;
    end
    return w;
  endfunction

  // the delay state still regulates, every other non-run state does not
  function automatic logic holds_off(input fstate_t s);
    return (s != ST_RUN) && (s != ST_DELAY);
  endfunction

  logic [NFAULT-1:0]       fault;
  logic [NFAULT-1:0][7:0]  resp;
  logic [NFAULT-1:0][7:0]  load_units;
  logic [NFAULT-1:0][23:0] dly_cyc;
  logic [NFAULT-1:0][23:0] rty_cyc;
  logic [NFAULT-1:0][23:0] unit_cyc;
  logic [23:0]             ot_unit;
  logic [23:0]             unit_ms;
  logic [3:0]              wsel;
  logic [NFAULT-1:0]       expired;

  assign fault[FAULT_UC] = r.sync[1];
  assign fault[FAULT_OT] = temp_reading > r.ot_limit;
  assign resp[FAULT_UC]  = r.uc_resp;
  assign resp[FAULT_OT]  = r.ot_resp;

  assign load_units[FAULT_UC] = {5'h00, delay_of(r.uc_resp)};
  assign load_units[FAULT_OT] = 8'(9'h001 << delay_of(r.ot_resp));

  // a zero unit register would end each unit after one cycle, so it counts as one base unit
  assign unit_ms = (ot_time_unit_ms == 8'h00) ? 24'h000001 : {16'h0000, ot_time_unit_ms};
  assign ot_unit = 24'(OT_BASE_CYC) * unit_ms;

  // a write to an unknown code selects nothing and is dropped
  assign wsel = reg_wr ? cmd_sel(reg_cmd) : 4'h0;
  assign dly_cyc[FAULT_UC] = 24'(UC_DELAY_CYC);
  assign rty_cyc[FAULT_UC] = 24'(UC_RETRY_CYC);
  assign dly_cyc[FAULT_OT] = ot_unit;
  assign rty_cyc[FAULT_OT] = ot_unit;

  genvar g;
  generate
    for (g = 0; g < NFAULT; g++) begin : g_unit
      assign unit_cyc[g] = (r.st[g] == ST_DELAY) ? dly_cyc[g] : rty_cyc[g];
      assign expired[g]  = (r.units[g] == 8'h00);
    end
  endgenerate

  always_comb begin
    next_r = r;
    // first stage is read only by the second
    next_r.sync = {r.sync[0], uc_fault_pin};

    if (wsel[0]) begin
      next_r.uc_resp = reg_wdata[7:0];
    end
    if (wsel[1]) begin
      next_r.ot_limit = reg_wdata;
    end
    if (wsel[2]) begin
      next_r.ot_resp = reg_wdata[7:0];
    end
    if (wsel[3]) begin
      next_r.ot_warn = reg_wdata;
    end

    // read data is registered and held until the next read
    if (reg_rd) begin
      next_r.rdata = read_word(cmd_sel(reg_cmd), r);
    end

    // set wins over clear
    next_r.warn = (temp_reading > r.ot_warn) | (r.warn & ~clear_faults);

    for (int i = 0; i < NFAULT; i++) begin
      // each fault keeps its own bit
      next_r.stat[i] = fault[i] | (r.stat[i] & ~clear_faults);

      // prescaler counts one unit, then the unit count steps down
      if (r.units[i] != 8'h00) begin
        if (r.pre[i] + 24'h000001 >= unit_cyc[i]) begin
          next_r.pre[i]   = 24'h000000;
          next_r.units[i] = r.units[i] - 8'h01;
        end else begin
          next_r.pre[i] = r.pre[i] + 24'h000001;
        end
      end

      case (r.st[i])
        // regulating, waiting for a fault
        ST_RUN: begin
          if (fault[i]) begin
            case (mode_of(resp[i]))
              MODE_DELAY: begin
                next_r.st[i]    = ST_DELAY;
                next_r.units[i] = load_units[i];
                next_r.pre[i]   = 24'h000000;
              end
              MODE_DISABLE_RETRY: begin
                if (retry_of(resp[i]) == 3'b000) begin
                  next_r.st[i] = ST_LATCHED;
                end else begin
                  next_r.st[i]    = ST_RETRY_WAIT;
                  next_r.tries[i] = retry_of(resp[i]);
                  next_r.units[i] = load_units[i];
                  next_r.pre[i]   = 24'h000000;
                end
              end
              MODE_RESUME_OK: next_r.st[i] = ST_HOLD;
              default: ;
            endcase
          end
        end

        // still regulating; an undercurrent delay field of 0 expires at once
        ST_DELAY: begin
          if (expired[i]) begin
            if (!fault[i]) begin
              next_r.st[i] = ST_RUN;
            end else if (retry_of(resp[i]) == 3'b000) begin
              next_r.st[i] = ST_LATCHED;
            end else begin
              next_r.st[i]    = ST_RETRY_WAIT;
              next_r.tries[i] = retry_of(resp[i]);
              next_r.units[i] = load_units[i];
              next_r.pre[i]   = 24'h000000;
            end
          end
        end

        ST_RETRY_WAIT: begin
          // each expiry is one restart attempt, judged on the fault level then
          if (expired[i]) begin
            if (!fault[i]) begin
              next_r.st[i] = ST_RUN;
            end else if (r.tries[i] > 3'b001) begin
              next_r.tries[i] = r.tries[i] - 3'b001;
              next_r.units[i] = load_units[i];
              next_r.pre[i]   = 24'h000000;
            end else begin
              next_r.st[i] = ST_LATCHED;
            end
          end
        end

        // output off until the fault goes
        ST_HOLD: begin
          if (!fault[i]) begin
            next_r.st[i] = ST_RUN;
          end
        end

        // only a clear brings it back
        ST_LATCHED: begin
          if (clear_faults) begin
            next_r.st[i] = ST_RUN;
          end
        end
        // unused codes fall back to run
        default: next_r.st[i] = ST_RUN;
      endcase
    end

    // warning never touches the output
    next_r.out_en = 1'b1;
    for (int i = 0; i < NFAULT; i++) begin
      if (holds_off(next_r.st[i])) begin
        next_r.out_en = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r          <= '0;
      r.uc_resp  <= UC_RESP_RST;
      r.ot_resp  <= OT_RESP_RST;
      r.ot_limit <= OT_LIMIT_RST;
      r.ot_warn  <= OT_WARN_RST;
      for (int i = 0; i < NFAULT; i++) begin
        r.st[i] <= ST_RUN;
      end
      r.out_en   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata       = r.rdata;
  assign output_enable   = r.out_en;
  assign status_uc_fault = r.stat[FAULT_UC];
  assign status_ot_fault = r.stat[FAULT_OT];
  assign status_ot_warn  = r.warn;
  // open drain: only ever pulls low
  assign alert_line_n_o  = 1'b0;
  assign alert_line_n_oe = (|r.stat) | r.warn;

endmodule

//--- rtl/fault_resp_pkg.sv
// Purpose: shared constants and types of the fault-response controller
// Assumes: 20 MHz mclk; command codes double as register addresses
// Notes:   time units are given in microseconds, cycle counts derive from them
package fault_resp_pkg;

  // command codes
  localparam logic [7:0] CMD_UC_RESP  = 8'h4c;
  localparam logic [7:0] CMD_OT_LIMIT = 8'h4f;
  localparam logic [7:0] CMD_OT_RESP  = 8'h50;
  localparam logic [7:0] CMD_OT_WARN  = 8'h51;

  // response byte layout
  localparam int MODE_HI  = 7;
  localparam int MODE_LO  = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  // reset values
  localparam logic [7:0]  UC_RESP_RST  = 8'h00;
  localparam logic [7:0]  OT_RESP_RST  = 8'h00;
  localparam logic [15:0] OT_LIMIT_RST = 16'h7fff;
  localparam logic [15:0] OT_WARN_RST  = 16'h7fff;

  // timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int UC_DELAY_UNIT_US = 10_000;
  localparam int UC_RETRY_UNIT_US = 8_200;
  localparam int OT_BASE_UNIT_US  = 1_000;
  localparam int UC_DELAY_CYCLES = UC_DELAY_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int UC_RETRY_CYCLES = UC_RETRY_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int OT_BASE_CYCLES  = OT_BASE_UNIT_US * (CLK_HZ / 1_000_000);

  // fault indices
  localparam int FAULT_UC = 0;
  localparam int FAULT_OT = 1;
  localparam int NFAULT   = 2;

  typedef enum logic [1:0] {
    MODE_IGNORE        = 2'b00,
    MODE_DELAY         = 2'b01,
    MODE_DISABLE_RETRY = 2'b10,
    MODE_RESUME_OK     = 2'b11
  } resp_mode_t;

  typedef enum logic [2:0] {
    ST_RUN        = 3'b000,
    ST_DELAY      = 3'b001,
    ST_RETRY_WAIT = 3'b010,
    ST_HOLD       = 3'b011,
    ST_LATCHED    = 3'b100
  } fstate_t;

endpackage

//--- tb/fault_host.sv
// Purpose: host side of the command bus
// Assumes: every call starts at a falling mclk edge
// Notes:   write data idles on an inverted pattern after a read
`timescale 1ns/1ps
module fault_host (
  input  wire logic        mclk,
  output logic      [7:0]  reg_cmd,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial {reg_cmd, reg_wr, reg_rd, reg_wdata} = '0;
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    reg_cmd = c;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    reg_cmd = c;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_wdata = ~reg_wdata;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule

//--- tb/fault_response_controller_asserts.sv
// Purpose: port-level checks of the fault-response controller
// Assumes: response bytes shadowed from the write strobes
// Notes:   second reset mid-run not exercised
`timescale 1ns/1ps
module fault_response_controller_asserts
  import fault_resp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_cmd,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        uc_fault_pin,
  input wire logic [15:0] temp_reading,
  input wire logic        clear_faults,
  input wire logic        output_enable,
  input wire logic        alert_line_n_o,
  input wire logic        alert_line_n_oe,
  input wire logic        status_uc_fault,
  input wire logic        status_ot_fault,
  input wire logic        status_ot_warn
);
  logic [7:0] uc_r;
  logic [7:0] ot_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      uc_r <= UC_RESP_RST;
      ot_r <= OT_RESP_RST;
    end else if (reg_wr && reg_cmd == CMD_UC_RESP) begin
      uc_r <= reg_wdata[7:0];
    end else if (reg_wr && reg_cmd == CMD_OT_RESP) begin
      ot_r <= reg_wdata[7:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  reset_state_a: assert property ($rose(rst_b) |-> output_enable && !alert_line_n_oe)
    else $error("bad state after reset");
  alert_or_a: assert property (alert_line_n_oe == (status_uc_fault | status_ot_fault |
    status_ot_warn) && !alert_line_n_o)
    else $error("alert not tied to status");
  uc_status_a: assert property (uc_fault_pin [*4] |=> status_uc_fault)
    else $error("undercurrent bit missing");
  ot_status_a: assert property (temp_reading == 16'hffff |=> status_ot_fault && status_ot_warn)
    else $error("temperature bits missing");
  clear_status_a: assert property (!uc_fault_pin [*4] ##0 (clear_faults && temp_reading ==
    16'h0000) |=> !status_uc_fault && !status_ot_fault && !status_ot_warn)
    else $error("status not cleared");
  ignore_run_a: assert property (uc_r[7:6] == 2'b00 && ot_r[7:6] == 2'b00 && output_enable
    |=> output_enable)
    else $error("output dropped when ignoring");
  disable_now_a: assert property (uc_r[7] && $rose(status_uc_fault) |-> !output_enable)
    else $error("output not cut with fault");
  resp_readback_a: assert property (reg_wr && reg_cmd == CMD_OT_RESP ##1 reg_rd && reg_cmd ==
    CMD_OT_RESP |-> ##2 reg_rdata == {8'h00, $past(reg_wdata[7:0], 3)})
    else $error("response byte readback wrong");
  cover property (uc_r[7:6] == 2'b01 && $fell(output_enable));
  cover property ($rose(status_ot_warn) && output_enable);
  cover property (uc_r[5:3] != 3'b000 && $rose(output_enable));
endmodule
bind fault_response_controller fault_response_controller_asserts u_chk (
  .mclk(mclk), .rst_b(rst_b), .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .uc_fault_pin(uc_fault_pin),
  .temp_reading(temp_reading), .clear_faults(clear_faults), .output_enable(output_enable),
  .alert_line_n_o(alert_line_n_o), .alert_line_n_oe(alert_line_n_oe),
  .status_uc_fault(status_uc_fault), .status_ot_fault(status_ot_fault),
  .status_ot_warn(status_ot_warn));

//--- tb/fault_response_controller_bench.sv
// Purpose: self-checking bench of the fault-response controller
// Assumes: shortened unit counts UCD, UCR and OTB
// Notes:   status word is {alert data, enable, alert, uc, ot, warn}
`timescale 1ns/1ps
module fault_response_controller_bench;
  import fault_resp_pkg::*;
  localparam int UCD = 10;
  localparam int UCR = 8;
  localparam int OTB = 5;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pin = 1'b0;
  logic        clr = 1'b0;
  logic [15:0] temp = 16'h0000;
  logic [7:0]  unit = 8'h01;
  logic [7:0]  cmd;
  logic        wr, rd, en, ao, aoe, suc, sot, swn;
  logic [15:0] wd, rdat, d;
  logic [31:0] seed = 32'hd909;
  int          n_fail = 0;
  int          check_count = 0;
  int          m[int];
  wire  [15:0] stv = {10'h000, ao, en, aoe, suc, sot, swn};
  always #25 mclk = ~mclk;
  fault_host host (.mclk(mclk), .reg_cmd(cmd), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wd), .reg_rdata(rdat));
  fault_response_controller #(.UC_DELAY_CYC(UCD), .UC_RETRY_CYC(UCR),
    .OT_BASE_CYC(OTB)) DUT (.mclk(mclk), .rst_b(rst_b), .reg_cmd(cmd),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat),
    .uc_fault_pin(pin), .temp_reading(temp), .ot_time_unit_ms(unit),
    .clear_faults(clr), .output_enable(en), .alert_line_n_o(ao),
    .alert_line_n_oe(aoe), .status_uc_fault(suc), .status_ot_fault(sot),
    .status_ot_warn(swn));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one phase: drive the fault sources, wait, compare the status word
  task ph(input logic p, input logic [15:0] t, input int h, input logic [15:0] e);
    pin = p;
    temp = t;
    cyc(h);
    chk(stv, e);
  endtask
  task fin;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
    chk(stv, 16'h0010);
  endtask
  task cfg(input logic [7:0] u, input logic [7:0] o);
    host.wr(CMD_UC_RESP, {8'h00, u});
    host.wr(CMD_OT_RESP, {8'h00, o});
    host.rd(CMD_OT_RESP, d);
    chk(d, {8'h00, o});
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    wrap_up;
  end
  initial begin
    m[CMD_UC_RESP] = UC_RESP_RST;
    m[CMD_OT_RESP] = OT_RESP_RST;
    m[CMD_OT_LIMIT] = OT_LIMIT_RST;
    m[CMD_OT_WARN] = OT_WARN_RST;
    cyc(5);
    rst_b = 1'b1;
    cyc(1);
    chk(stv, 16'h0010);
    // no fault is present, so random settings cannot disturb the output here
    for (int k = 0; k < 3; k++) begin
      foreach (m[c]) begin
        host.rd(8'(c), d);
        chk(d, 16'(m[c]));
        seed = xorshift(seed);
        host.wr(8'(c), seed[15:0]);
        m[c] = (c == CMD_UC_RESP || c == CMD_OT_RESP) ? seed[7:0] : seed[15:0];
      end
    end
    host.wr(8'h4d, 16'h1234);
    host.rd(8'h4d, d);
    chk(d, 16'h0000);
    host.wr(CMD_OT_LIMIT, 16'h0100);
    host.wr(CMD_OT_WARN, 16'h0080);
    cfg(8'h00, 8'h00);
    ph(1, 0, 5, 16'h001c);
    ph(0, 0, 5, 16'h001c);
    fin;
    cfg(8'h80, 8'h00);
    ph(1, 0, 5, 16'h000c);
    ph(0, 0, 10, 16'h000c);
    fin;
    cfg(8'hc0, 8'h00);
    ph(1, 0, 5, 16'h000c);
    ph(0, 0, 5, 16'h001c);
    fin;
    cfg(8'h42, 8'h00);
    ph(1, 0, UCD * 2 - 3, 16'h001c);
    ph(1, 0, 10, 16'h000c);
    ph(0, 0, 10, 16'h000c);
    fin;
    cfg(8'h91, 8'h00);
    ph(1, 0, 5, 16'h000c);
    ph(0, 0, 4, 16'h000c);
    ph(0, 0, UCR + 2, 16'h001c);
    fin;
    cfg(8'h89, 8'h00);
    ph(1, 0, UCR + 6, 16'h000c);
    ph(0, 0, UCR + 6, 16'h000c);
    fin;
    unit = 8'h02;
    cfg(8'h00, 8'hc0);
    ph(0, 16'h0090, 3, 16'h0019);
    ph(0, 16'hffff, 3, 16'h000b);
    ph(0, 0, 5, 16'h001b);
    fin;
    cfg(8'h00, 8'h41);
    ph(0, 16'h0200, 4 * OTB - 5, 16'h001b);
    ph(0, 16'h0200, 10, 16'h000b);
    ph(0, 0, 5, 16'h000b);
    fin;
    wrap_up;
  end
endmodule
